// File: hw/inag_cmd.sv
// device-side handler for the immediate idle and set-geometry commands
//
// Contract
// - idle done: busy 0, ready 1, others 0
// - no power management: abort idle command
// - either command may abort on failure
// - error done: busy/xfer 0, fault, summary
// - completion keeps drive select bit
// - idle state entered at once
// - geometry opcode 91h, count and head
// - geometry accepted regardless of ready
// - geometry done: busy, fault, xfer, summary 0
// - bad mapping: abort, clear valid, zero words
// - default mapping always supported
// - no mapping: media commands fail no-id
// - fixed words and capacity stay unchanged
// - word55 head plus one, word56 sectors
// - word54 capacity quotient capped at ffff
// - large capacity uses fixed limit dividend
// - words 58:57 product of 54,55,56
`default_nettype none
module inag_cmd
  import inag_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        fault_pin,
  output logic             host_interrupt_line,
  output logic             irq,
  output logic             idle_mode,
  output logic             media_cmd_pulse
);

  logic        rst_a_ff, rst_n;
  logic        flt_s1_ff, flt_s2_ff, flt_s3_ff, fault_lvl_ff, fault_old_ff;
  logic [7:0]  failure_cause_ff, count_parameter_ff, drive_select_head_ff;
  logic        busy_ff, ready_ff, fault_ff, err_sum_ff;
  logic        pm_supported_ff;
  logic [27:0] capacity_ff;
  logic [7:0]  id_index_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic [31:0] rdata_ff;
  logic        host_interrupt_line_ff, idle_ff, media_ff, done_ff;
  inag_state_e state_ff;
  logic [7:0]  res_err_ff;
  logic        res_geom_ff, res_div_ff;
  logic        geom_valid_ff;
  logic [15:0] w54_ff;
  logic [4:0]  w55_ff;
  logic [7:0]  w56_ff;
  logic [31:0] w5857_ff;
  logic [23:0] div_q_ff;
  logic [13:0] div_r_ff;
  logic [12:0] divisor_ff;
  logic [4:0]  div_cnt_ff;

  logic        cmd_wr, geom_ok, start_div;
  logic [7:0]  opcode;
  logic [13:0] rem_sh;
  logic [15:0] nxt_w54;
  logic [31:0] nxt_w5857;
  logic [7:0]  fin_err;
  logic [7:0]  status_byte;
  logic [15:0] id_word;
  logic [23:0] dividend;
  logic [IRQ_W-1:0] irq_events;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_ff <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n    <= rst_a_ff;
    end
  end

  // fault pin: three flops, level taken when the last two agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_s1_ff    <= 1'b0;
      flt_s2_ff    <= 1'b0;
      flt_s3_ff    <= 1'b0;
      fault_lvl_ff <= 1'b0;
      fault_old_ff <= 1'b0;
    end else begin
      flt_s1_ff    <= fault_pin;
      flt_s2_ff    <= flt_s1_ff;
      flt_s3_ff    <= flt_s2_ff;
      fault_old_ff <= fault_lvl_ff;
      if (flt_s2_ff == flt_s3_ff) begin
        fault_lvl_ff <= flt_s3_ff;
      end
    end
  end

  assign opcode    = reg_wdata[7:0];
  assign cmd_wr    = reg_wr && (reg_addr == OFF_OPCODE) && !busy_ff;
  // any sector count 1..63 with any top head is a supported mapping
  assign geom_ok   = (count_parameter_ff != 8'h00) && (count_parameter_ff <= MAX_SPT);
  assign start_div = cmd_wr && (opcode == OP_SET_GEOM) && geom_ok;
  assign dividend  = (capacity_ff > {4'h0, CHS_LIMIT}) ? CHS_LIMIT : capacity_ff[23:0];

  // software-owned registers; writes are ignored while a command runs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_parameter_ff   <= 8'h00;
      drive_select_head_ff <= 8'h00;
      pm_supported_ff      <= PM_RST;
      capacity_ff          <= CAP_RST;
      id_index_ff          <= 8'h00;
      irq_mask_ff          <= IRQ_MASK_RST;
    end else if (reg_wr && !busy_ff) begin
      case (reg_addr)
        OFF_COUNT:    count_parameter_ff   <= reg_wdata[7:0];
        OFF_DRV_HEAD: drive_select_head_ff <= reg_wdata[7:0];
        OFF_CONFIG:   pm_supported_ff      <= reg_wdata[0];
        OFF_CAPACITY: capacity_ff          <= reg_wdata[27:0];
        OFF_ID_INDEX: id_index_ff          <= reg_wdata[7:0];
        OFF_IRQ_MASK: irq_mask_ff          <= reg_wdata[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // divider: capped capacity over heads times sectors, one bit a cycle
  assign rem_sh = {div_r_ff[12:0], div_q_ff[23]};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q_ff   <= 24'h000000;
      div_r_ff   <= 14'h0000;
      divisor_ff <= 13'h0001;
      div_cnt_ff <= 5'h00;
    end else if (start_div) begin
      div_q_ff   <= dividend;
      div_r_ff   <= 14'h0000;
      divisor_ff <= {8'h00, drive_select_head_ff[3:0] + 5'h01} * {5'h00, count_parameter_ff};
      div_cnt_ff <= DIV_STEPS;
    end else if (state_ff == S_DIVIDE) begin
      div_cnt_ff <= div_cnt_ff - 5'h01;
      if (rem_sh >= {1'b0, divisor_ff}) begin
        div_r_ff <= rem_sh - {1'b0, divisor_ff};
        div_q_ff <= {div_q_ff[22:0], 1'b1};
      end else begin
        div_r_ff <= rem_sh;
        div_q_ff <= {div_q_ff[22:0], 1'b0};
      end
    end
  end

  assign nxt_w54   = (div_q_ff > {8'h00, W54_MAX}) ? W54_MAX : div_q_ff[15:0];
  assign nxt_w5857 = {16'h0000, nxt_w54} * {27'h0000000, w55_ff} * {24'h000000, w56_ff};
  // a device fault turns any completion into an aborted one
  assign fin_err   = res_err_ff | (fault_lvl_ff ? ERR_ABORTED : 8'h00);

  // command sequencer, task-file flags and identify geometry words
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= S_WAIT;
      busy_ff          <= 1'b0;
      ready_ff         <= READY_RST;
      fault_ff         <= 1'b0;
      err_sum_ff       <= 1'b0;
      failure_cause_ff <= 8'h00;
      res_err_ff       <= 8'h00;
      res_geom_ff      <= 1'b0;
      res_div_ff       <= 1'b0;
      idle_ff          <= 1'b0;
      media_ff         <= 1'b0;
      done_ff          <= 1'b0;
      geom_valid_ff    <= 1'b1;
      w54_ff           <= DEF_CYL;
      w55_ff           <= DEF_HEADS[4:0];
      w56_ff           <= DEF_SPT[7:0];
      w5857_ff         <= DEF_CUR_CAP;
    end else begin
      media_ff <= 1'b0;
      done_ff  <= 1'b0;
      case (state_ff)
        S_WAIT: begin
          // set-geometry does not look at the ready flag
          if (cmd_wr) begin
            busy_ff          <= 1'b1;
            failure_cause_ff <= 8'h00;
            res_err_ff       <= 8'h00;
            res_geom_ff      <= 1'b0;
            res_div_ff       <= 1'b0;
            state_ff         <= S_FINISH;
            case (opcode)
              OP_IDLE_NOW: begin
                if (!pm_supported_ff) begin
                  res_err_ff <= ERR_ABORTED;
                end else begin
                  idle_ff <= 1'b1;
                end
              end
              OP_SET_GEOM: begin
                res_geom_ff <= 1'b1;
                if (geom_ok) begin
                  w55_ff     <= drive_select_head_ff[3:0] + 5'h01;
                  w56_ff     <= count_parameter_ff;
                  res_div_ff <= 1'b1;
                  state_ff   <= S_DIVIDE;
                end else begin
                  res_err_ff    <= ERR_ABORTED;
                  geom_valid_ff <= 1'b0;
                  w54_ff        <= 16'h0000;
                  w55_ff        <= 5'h00;
                  w56_ff        <= 8'h00;
                  w5857_ff      <= 32'h00000000;
                end
              end
              OP_MEDIA_RD, OP_MEDIA_WR: begin
                if (!geom_valid_ff) begin
                  res_err_ff <= ERR_NO_ID | ERR_ABORTED;
                end else begin
                  idle_ff  <= 1'b0;
                  media_ff <= 1'b1;
                end
              end
              default: res_err_ff <= ERR_ABORTED;
            endcase
          end
        end
        S_DIVIDE: begin
          if (div_cnt_ff == 5'h01) begin
            state_ff <= S_FINISH;
          end
        end
        S_FINISH: begin
          // drive/head register is left as the host wrote it
          busy_ff          <= 1'b0;
          fault_ff         <= fault_lvl_ff;
          failure_cause_ff <= fin_err;
          err_sum_ff       <= |fin_err;
          done_ff          <= 1'b1;
          if (!res_geom_ff) begin
            ready_ff <= 1'b1;
          end
          if (res_div_ff && (fin_err == 8'h00)) begin
            geom_valid_ff <= 1'b1;
            w54_ff        <= nxt_w54;
            w5857_ff      <= nxt_w5857;
          end
          state_ff <= S_WAIT;
        end
        default: state_ff <= S_WAIT;
      endcase
    end
  end

  // status byte: no data phase, so the transfer request bit stays zero
  assign status_byte = {busy_ff, ready_ff, fault_ff, 1'b0, 1'b0, 2'b00, err_sum_ff};

  // identify words; fixed words and capacity never change here
  always_comb begin
    case (id_index_ff)
      IDW_CYL:      id_word = DEF_CYL;
      IDW_HEADS:    id_word = DEF_HEADS;
      IDW_SPT:      id_word = DEF_SPT;
      IDW_VALID:    id_word = {15'h0000, geom_valid_ff};
      IDW_CUR_CYL:  id_word = w54_ff;
      IDW_CUR_HEAD: id_word = {11'h000, w55_ff};
      IDW_CUR_SPT:  id_word = {8'h00, w56_ff};
      IDW_CAP_LO:   id_word = w5857_ff[15:0];
      IDW_CAP_HI:   id_word = w5857_ff[31:16];
      IDW_ADDR_LO:  id_word = capacity_ff[15:0];
      IDW_ADDR_HI:  id_word = {4'h0, capacity_ff[27:16]};
      default:      id_word = 16'h0000;
    endcase
  end

  // interrupt status: set wins over a write-one clear
  assign irq_events = {fault_lvl_ff && !fault_old_ff, done_ff && err_sum_ff, done_ff};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
    end else if (reg_wr && (reg_addr == OFF_IRQ_STAT)) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_events;
    end
  end

  // task-file interrupt: raised at completion, dropped by a status read or a new command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_interrupt_line_ff <= 1'b0;
    end else if (done_ff) begin
      host_interrupt_line_ff <= 1'b1;
    end else if ((reg_rd && (reg_addr == OFF_CMD_STATE)) || cmd_wr) begin
      host_interrupt_line_ff <= 1'b0;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_FAILURE:   rdata_ff <= {24'h000000, failure_cause_ff};
        OFF_COUNT:     rdata_ff <= {24'h000000, count_parameter_ff};
        OFF_DRV_HEAD:  rdata_ff <= {24'h000000, drive_select_head_ff};
        OFF_CMD_STATE: rdata_ff <= {24'h000000, status_byte};
        OFF_IRQ_STAT:  rdata_ff <= {29'h00000000, irq_stat_ff};
        OFF_IRQ_MASK:  rdata_ff <= {29'h00000000, irq_mask_ff};
        OFF_CONFIG:    rdata_ff <= {31'h00000000, pm_supported_ff};
        OFF_CAPACITY:  rdata_ff <= {4'h0, capacity_ff};
        OFF_ID_INDEX:  rdata_ff <= {24'h000000, id_index_ff};
        OFF_ID_DATA:   rdata_ff <= {16'h0000, id_word};
        OFF_GEOM_STAT: rdata_ff <= {30'h00000000, idle_ff, geom_valid_ff};
        default:       rdata_ff <= 32'h00000000;
      endcase
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign reg_rdata           = rdata_ff;
  assign host_interrupt_line = host_interrupt_line_ff;
  assign irq                 = |(irq_stat_ff & irq_mask_ff);
  assign idle_mode           = idle_ff;
  assign media_cmd_pulse     = media_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_idle_start;
    cmd_wr && (opcode == OP_IDLE_NOW);
  endsequence

  sequence seq_geom_good;
    start_div;
  endsequence

  sequence seq_div_run;
    (state_ff == S_DIVIDE) [*8] ##1 (state_ff == S_DIVIDE) [*8] ##1 (state_ff == S_DIVIDE) [*8]
      ##1 (state_ff == S_FINISH);
  endsequence

  a_idle_ok_flags: assert property (seq_idle_start ##0 pm_supported_ff && !fault_lvl_ff ##1 !fault_lvl_ff
    |=> !busy_ff && ready_ff && !fault_ff && !err_sum_ff && idle_mode)
    else $error("idle completion flags wrong");
  a_idle_abort_pm: assert property (seq_idle_start ##0 !pm_supported_ff
    |-> ##2 failure_cause_ff[BIT_ABORTED] && err_sum_ff && (idle_mode == $past(idle_mode, 2)))
    else $error("idle not aborted without power management");
  a_err_summary: assert property (!busy_ff |-> (err_sum_ff == (|failure_cause_ff)))
    else $error("error summary disagrees with error register");
  a_done_interrupt: assert property (done_ff |-> !busy_ff ##1 host_interrupt_line)
    else $error("completion did not raise interrupt line");
  a_drive_bit_kept: assert property (busy_ff && $past(busy_ff) |-> $stable(drive_select_head_ff))
    else $error("drive select changed during command");
  a_geom_any_ready: assert property (cmd_wr && (opcode == OP_SET_GEOM) |=> busy_ff)
    else $error("geometry refused while not ready");
  a_bad_map_abort: assert property (cmd_wr && (opcode == OP_SET_GEOM) && !geom_ok
    |=> !geom_valid_ff && (w54_ff == 16'h0000) ##1 failure_cause_ff[BIT_ABORTED])
    else $error("unsupported mapping not aborted");
  a_media_no_id: assert property (cmd_wr && (opcode == OP_MEDIA_RD) && !geom_valid_ff
    |-> ##2 failure_cause_ff[BIT_NO_ID] && !media_cmd_pulse)
    else $error("media access without mapping not failed");
  a_geom_words: assert property (seq_geom_good |=> (w55_ff == $past(drive_select_head_ff[3:0]) + 5'h01)
    && (w56_ff == $past(count_parameter_ff)))
    else $error("heads or sectors word wrong");
  a_div_latency: assert property (seq_geom_good |=> seq_div_run ##1 (state_ff == S_WAIT) && done_ff)
    else $error("geometry command latency wrong");
  a_w54_cap: assert property (done_ff && $past(res_div_ff) && geom_valid_ff
    |-> (w54_ff <= W54_MAX) && ({8'h00, w54_ff} <= div_q_ff))
    else $error("cylinder word exceeds quotient");
  a_cap_product: assert property (done_ff && $past(res_div_ff) && geom_valid_ff
    |-> w5857_ff == {16'h0000, w54_ff} * {27'h0000000, w55_ff} * {24'h000000, w56_ff})
    else $error("current capacity not the product");

endmodule : inag_cmd
`default_nettype wire

// File: hw/inag_pkg.sv
// constants and types shared by the idle and geometry command handler
`default_nettype none
package inag_pkg;
  // register map, byte addresses of 32-bit words
  localparam logic [7:0]  OFF_FAILURE   = 8'h00;
  localparam logic [7:0]  OFF_COUNT     = 8'h04;
  localparam logic [7:0]  OFF_DRV_HEAD  = 8'h08;
  localparam logic [7:0]  OFF_CMD_STATE = 8'h0c;
  localparam logic [7:0]  OFF_OPCODE    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h18;
  localparam logic [7:0]  OFF_CONFIG    = 8'h1c;
  localparam logic [7:0]  OFF_CAPACITY  = 8'h20;
  localparam logic [7:0]  OFF_ID_INDEX  = 8'h24;
  localparam logic [7:0]  OFF_ID_DATA   = 8'h28;
  localparam logic [7:0]  OFF_GEOM_STAT = 8'h2c;
  // opcodes
  localparam logic [7:0]  OP_IDLE_NOW   = 8'he1;
  localparam logic [7:0]  OP_SET_GEOM   = 8'h91;
  localparam logic [7:0]  OP_MEDIA_RD   = 8'h20;
  localparam logic [7:0]  OP_MEDIA_WR   = 8'h30;
  // status byte, error byte and drive/head fields
  localparam int          BIT_BUSY      = 7;
  localparam int          BIT_READY     = 6;
  localparam int          BIT_FAULT     = 5;
  localparam int          BIT_XFER      = 3;
  localparam int          BIT_ERR_SUM   = 0;
  localparam int          BIT_ABORTED   = 2;
  localparam int          BIT_NO_ID     = 4;
  localparam int          BIT_DRV_SEL   = 4;
  localparam logic [7:0]  ERR_ABORTED   = 8'h04;
  localparam logic [7:0]  ERR_NO_ID     = 8'h10;
  // geometry limits and defaults
  localparam logic [23:0] CHS_LIMIT     = 24'hfbfc10;
  localparam logic [15:0] W54_MAX       = 16'hffff;
  localparam logic [7:0]  MAX_SPT       = 8'h3f;
  localparam logic [15:0] DEF_CYL       = 16'h3fff;
  localparam logic [15:0] DEF_HEADS     = 16'h0010;
  localparam logic [15:0] DEF_SPT       = 16'h003f;
  localparam logic [31:0] DEF_CUR_CAP   = 32'h00fbfc10;
  localparam logic [27:0] CAP_RST       = 28'h0fbfc10;
  localparam logic [4:0]  DIV_STEPS     = 5'h18;
  // identify word numbers
  localparam logic [7:0]  IDW_CYL       = 8'h01;
  localparam logic [7:0]  IDW_HEADS     = 8'h03;
  localparam logic [7:0]  IDW_SPT       = 8'h06;
  localparam logic [7:0]  IDW_VALID     = 8'h35;
  localparam logic [7:0]  IDW_CUR_CYL   = 8'h36;
  localparam logic [7:0]  IDW_CUR_HEAD  = 8'h37;
  localparam logic [7:0]  IDW_CUR_SPT   = 8'h38;
  localparam logic [7:0]  IDW_CAP_LO    = 8'h39;
  localparam logic [7:0]  IDW_CAP_HI    = 8'h3a;
  localparam logic [7:0]  IDW_ADDR_LO   = 8'h3c;
  localparam logic [7:0]  IDW_ADDR_HI   = 8'h3d;
  // interrupt status bits and reset values
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_ABORT     = 1;
  localparam int          IRQ_FAULT     = 2;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;
  localparam logic        PM_RST        = 1'b1;
  localparam logic        READY_RST     = 1'b1;

  typedef enum logic [1:0] {
    S_WAIT,
    S_DIVIDE,
    S_FINISH
  } inag_state_e;
endpackage : inag_pkg
`default_nettype wire

// File: testbench/inag_host.sv
// host controller model: register bus master issuing task-file commands
`default_nettype none
module inag_host
  import inag_pkg::*;
(
  input  wire logic        ref_clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic cmd(input logic [7:0] op);
    logic [31:0] st;
    if (op == OP_IDLE_NOW) begin
      rd(OFF_CMD_STATE, st);
      if (st[BIT_READY] !== 1'b1) return;
    end
    wr(OFF_OPCODE, {24'h0, op});
  endtask : cmd
endmodule : inag_host
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the idle and geometry command handler
`default_nettype none
module testbench
  import inag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        fault_pin;
  logic        host_interrupt_line;
  logic        irq;
  logic        idle_mode;
  logic        media_cmd_pulse;
  int          n_mismatch;
  int          n_tests;
  int          n_media = 0;

  inag_host u_host (
    .ref_clk   (ref_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  inag_cmd u_dut (
    .ref_clk             (ref_clk),
    .arst_n              (arst_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .fault_pin           (fault_pin),
    .host_interrupt_line (host_interrupt_line),
    .irq                 (irq),
    .idle_mode           (idle_mode),
    .media_cmd_pulse     (media_cmd_pulse)
  );

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (media_cmd_pulse === 1'b1) n_media++;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    u_host.rd(a, v);
    chk(nm, exp, v);
  endtask : rdchk

  task automatic idw(input logic [7:0] w, input logic [15:0] exp);
    u_host.wr(OFF_ID_INDEX, {24'h0, w});
    rdchk($sformatf("identify word %0d", w), OFF_ID_DATA, {16'h0, exp});
  endtask : idw

  // issue, wait for the interrupt line, then read status and error
  task automatic run(input logic [7:0] op, input logic [7:0] exp_st, input logic [7:0] exp_err);
    int i;
    i = 0;
    u_host.cmd(op);
    do begin
      @(posedge ref_clk);
      #1;
      i++;
    end while (host_interrupt_line !== 1'b1 && i < 40);
    if (host_interrupt_line !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] interrupt line expected 1 seen %b", host_interrupt_line);
      conclude();
    end else begin
      rdchk("status", OFF_CMD_STATE, {24'h0, exp_st});
      chk("line after status read", 32'h0, {31'h0, host_interrupt_line});
      rdchk("error", OFF_FAILURE, {24'h0, exp_err});
    end
  endtask : run

  task automatic t_reset();
    rdchk("status", OFF_CMD_STATE, 32'h40);
    rdchk("irq mask", OFF_IRQ_MASK, 32'h0);
    rdchk("config", OFF_CONFIG, 32'h1);
    rdchk("geometry status", OFF_GEOM_STAT, 32'h1);
    rdchk("unmapped", 8'h3c, 32'h0);
    idw(IDW_CUR_CYL, DEF_CYL);
    idw(IDW_CUR_HEAD, DEF_HEADS);
    idw(IDW_CUR_SPT, DEF_SPT);
    $display("test reset done");
  endtask : t_reset

  task automatic t_idle();
    logic [31:0] v;
    u_host.wr(OFF_DRV_HEAD, 32'h10);
    u_host.wr(OFF_IRQ_MASK, 32'h7);
    run(OP_IDLE_NOW, 8'h40, 8'h00);
    chk("idle mode", 32'h1, {31'h0, idle_mode});
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("drive select", OFF_DRV_HEAD, 32'h10);
    u_host.rd(OFF_GEOM_STAT, v);
    chk("idle state", 32'h1, {31'h0, v[1]});
    u_host.wr(OFF_IRQ_MASK, 32'h0);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk("irq status", OFF_IRQ_STAT, 32'h1);
    u_host.wr(OFF_IRQ_STAT, 32'h1);
    rdchk("irq status cleared", OFF_IRQ_STAT, 32'h0);
    $display("test idle done");
  endtask : t_idle

  task automatic t_idle_abort();
    logic [31:0] v;
    u_host.wr(OFF_CONFIG, 32'h0);
    run(OP_IDLE_NOW, 8'h41, ERR_ABORTED);
    u_host.rd(OFF_IRQ_STAT, v);
    chk("error event", 32'h1, {31'h0, v[IRQ_ABORT]});
    u_host.wr(OFF_IRQ_STAT, 32'h7);
    u_host.wr(OFF_CONFIG, 32'h1);
    $display("test idle abort done");
  endtask : t_idle_abort

  task automatic t_fault();
    logic [31:0] v;
    @(posedge ref_clk);
    fault_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    run(OP_IDLE_NOW, 8'h61, ERR_ABORTED);
    u_host.rd(OFF_IRQ_STAT, v);
    chk("fault event", 32'h1, {31'h0, v[IRQ_FAULT]});
    @(posedge ref_clk);
    fault_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    u_host.wr(OFF_IRQ_STAT, 32'h7);
    $display("test fault done");
  endtask : t_fault

  task automatic t_geom();
    logic [27:0] cap [4] = '{28'h0fbfc10, 28'h0fbfc10, 28'h1000000, 28'h0010000};
    logic [7:0]  spt [4] = '{8'h3f, 8'h11, 8'h3f, 8'h10};
    logic [3:0]  hd  [4] = '{4'hf, 4'h3, 4'hf, 4'h3};
    logic [31:0] dv;
    logic [31:0] hs;
    logic [31:0] w54;
    logic [31:0] prod;
    for (int k = 0; k < 4; k++) begin
      dv = (cap[k] > {4'h0, CHS_LIMIT}) ? {8'h0, CHS_LIMIT} : {4'h0, cap[k]};
      hs = (32'(hd[k]) + 32'h1) * 32'(spt[k]);
      w54 = ((dv / hs) > 32'hffff) ? 32'hffff : dv / hs;
      prod = w54 * hs;
      u_host.wr(OFF_CAPACITY, {4'h0, cap[k]});
      u_host.wr(OFF_COUNT, {24'h0, spt[k]});
      u_host.wr(OFF_DRV_HEAD, {24'h0, 4'h1, hd[k]});
      run(OP_SET_GEOM, 8'h40, 8'h00);
      rdchk("drive select", OFF_DRV_HEAD, {24'h0, 4'h1, hd[k]});
      idw(IDW_CUR_HEAD, 16'(hd[k]) + 16'h1);
      idw(IDW_CUR_SPT, {8'h0, spt[k]});
      idw(IDW_CUR_CYL, w54[15:0]);
      idw(IDW_CAP_LO, prod[15:0]);
      idw(IDW_CAP_HI, prod[31:16]);
      idw(IDW_ADDR_LO, cap[k][15:0]);
      idw(IDW_ADDR_HI, {4'h0, cap[k][27:16]});
      idw(IDW_CYL, DEF_CYL);
      idw(IDW_HEADS, DEF_HEADS);
      idw(IDW_SPT, DEF_SPT);
    end
    $display("test geometry done");
  endtask : t_geom

  task automatic t_bad_map();
    logic [31:0] v;
    logic [7:0]  bad [2] = '{8'h00, 8'h40};
    int          m0;
    for (int k = 0; k < 2; k++) begin
      u_host.wr(OFF_COUNT, {24'h0, bad[k]});
      run(OP_SET_GEOM, 8'h41, ERR_ABORTED);
      u_host.rd(OFF_GEOM_STAT, v);
      chk("mapping valid", 32'h0, {31'h0, v[0]});
      u_host.wr(OFF_ID_INDEX, {24'h0, IDW_VALID});
      u_host.rd(OFF_ID_DATA, v);
      chk("word 53 bit 0", 32'h0, {31'h0, v[0]});
      for (int w = 54; w <= 58; w++) idw(8'(w), 16'h0);
    end
    m0 = n_media;
    run(OP_MEDIA_RD, 8'h41, ERR_NO_ID | ERR_ABORTED);
    chk("media pulses", 32'h0, 32'(n_media - m0));
    run(8'hee, 8'h41, ERR_ABORTED);
    u_host.wr(OFF_COUNT, 32'h3f);
    u_host.wr(OFF_DRV_HEAD, 32'h1f);
    run(OP_SET_GEOM, 8'h40, 8'h00);
    run(OP_MEDIA_WR, 8'h40, 8'h00);
    chk("media pulses", 32'h1, 32'(n_media - m0));
    chk("idle mode", 32'h0, {31'h0, idle_mode});
    $display("test bad mapping done");
  endtask : t_bad_map

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    fault_pin = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_idle();
    t_idle_abort();
    t_fault();
    t_geom();
    t_bad_map();
    conclude();
  end
endmodule : testbench
`default_nettype wire
